// >>> hw/pdp_pkg.sv
// Package with indices, field layouts, reset values and carrier types of the divider registers
package pdp_pkg;

	// Width of a control byte index and of a control byte
	localparam int unsigned IDX_W  = 6;
	localparam int unsigned BYTE_W = 8;

	// Control byte indices held by this block
	localparam logic [5:0] IDX_PERIPHERAL_PLL_M_AND_N_LOW   = 6'h0F;
	localparam logic [5:0] IDX_PERIPHERAL_PLL_N_HIGH        = 6'h10;
	localparam logic [5:0] IDX_PERIPHERAL_SPREAD_CODE_LOW   = 6'h11;
	localparam logic [5:0] IDX_PERIPHERAL_SPREAD_CODE_HIGH  = 6'h12;
	localparam logic [5:0] IDX_PERIPHERAL_N_LSB             = 6'h13;
	localparam logic [5:0] IDX_PROCESSOR_OUTPUT_DIVIDER     = 6'h14;

	// Reserved control byte range, no function implemented
	localparam logic [5:0] IDX_RESERVED_FIRST = 6'h15;
	localparam logic [5:0] IDX_RESERVED_LAST  = 6'h3F;

	// Field positions inside the peripheral M and N low byte
	localparam int unsigned POS_FEEDBACK_DIVIDER_MSB = 5;
	localparam int unsigned POS_REF_DIVIDER_BIT2     = 7;
	localparam int unsigned POS_REF_DIVIDER_BIT1     = 6;

	// Field positions of the N least significant bits and the ratio code
	localparam int unsigned POS_REF_DIVIDER_LSB        = 7;
	localparam int unsigned POS_PROCESSOR_RATIO_CODE_MSB = 3;

	// Field widths
	localparam int unsigned FEEDBACK_DIV_W = 6;
	localparam int unsigned REF_DIV_W      = 11;
	localparam int unsigned SPREAD_W       = 16;
	localparam int unsigned RATIO_CODE_W   = 4;
	localparam int unsigned RATIO_W        = 8;

	// Values after reset (fields power up undefined, cleared here)
	localparam logic [7:0]  RESET_BYTE       = 8'h00;
	localparam logic        RESET_BIT        = 1'b0;
	localparam logic [3:0]  RESET_RATIO_CODE = 4'h0;
	localparam logic [7:0]  RESET_DIVIDE_RATIO = 8'h02; // Decode of the reset ratio code

	// Default dividers used while divider programming is disabled
	localparam logic [5:0]  DEFAULT_FEEDBACK_DIV = 6'h00;
	localparam logic [10:0] DEFAULT_REF_DIV      = 11'h000;
	localparam logic        DEFAULT_PROC_N_LSB   = 1'b0;

	// Read answer of reserved bits and of reserved bytes
	localparam logic [7:0]  READ_ZERO = 8'h00;

	// One control byte request from the bus engine
	typedef struct packed
	{
		logic              write;
		logic              read;
		logic [IDX_W-1:0]  index;
		logic [BYTE_W-1:0] wdata;
	} pdp_req_t;

	// Divider pair of one PLL
	typedef struct packed
	{
		logic [FEEDBACK_DIV_W-1:0] feedbackDiv;
		logic [REF_DIV_W-1:0]      refDiv;
	} pdp_pll_t;

endpackage

// >>> hw/pdp_ratio_decode.sv
// Decoder from processor divider ratio code to divide value
`timescale 1ns/100ps

module pdp_ratio_decode #(
	// Ratios of the four codes whose encoding is still unconfirmed
	parameter logic [7:0] RATIO_CODE_3  = 8'h0F,
	parameter logic [7:0] RATIO_CODE_7  = 8'h1E,
	parameter logic [7:0] RATIO_CODE_11 = 8'h3C,
	parameter logic [7:0] RATIO_CODE_15 = 8'h78
)(
	// Ratio code in
	input  wire logic [pdp_pkg::RATIO_CODE_W-1:0] ratioCode,
	// Divide value out
	output logic      [pdp_pkg::RATIO_W-1:0]      divideRatio
);

	// Code to divide value, table order by code
	function automatic logic [7:0] decodeRatio(input logic [3:0] code);
		logic [7:0] value;
		value = 8'h02;
		case (code)
			4'h0:    value = 8'h02;
			4'h1:    value = 8'h03;
			4'h2:    value = 8'h05;
			4'h3:    value = RATIO_CODE_3;  // (R9)
			4'h4:    value = 8'h04;
			4'h5:    value = 8'h06;
			4'h6:    value = 8'h0A;
			4'h7:    value = RATIO_CODE_7;  // (R9)
			4'h8:    value = 8'h08;
			4'h9:    value = 8'h0C;
			4'hA:    value = 8'h14;
			4'hB:    value = RATIO_CODE_11; // (R9)
			4'hC:    value = 8'h10;
			4'hD:    value = 8'h18;
			4'hE:    value = 8'h28;
			4'hF:    value = RATIO_CODE_15; // (R9)
			default: value = 8'h02;
		endcase
		return value;
	endfunction

	// Pure lookup, registered by the caller
	always_comb
	begin
		divideRatio = decodeRatio(ratioCode); // (R8)
	end

endmodule

// >>> hw/pdp_regs.sv
// Divider and spread control bytes of the peripheral and processor PLLs
`timescale 1ns/100ps

// Behaviour
// (R1) Byte 15 bits 5..0 hold feedback divider
// (R2) N[10:3] byte 16, N[2:1] byte 15[7:6]
// (R3) Apply M/N only while programming enable set
// (R4) Byte 19 bit 7 holds peripheral N lsb
// (R5) Assembled M and N drive PLL frequency
// (R6) Bytes 17,18 hold 16-bit spread code
// (R7) Byte 20 bit 7 holds processor N lsb
// (R8) Byte 20 bits 3..0 select processor ratio
// (R9) Unconfirmed ratio codes are module parameters
// (R10) Bytes 21 to 63 implement nothing
// (R11) Reserved bits written zero, read zero
module pdp_regs #(
	// Ratios of the unconfirmed processor divider codes
	parameter logic [7:0] RATIO_CODE_3  = 8'h0F,
	parameter logic [7:0] RATIO_CODE_7  = 8'h1E,
	parameter logic [7:0] RATIO_CODE_11 = 8'h3C,
	parameter logic [7:0] RATIO_CODE_15 = 8'h78
)(
	// Clock and reset
	input  wire logic                                 clk,
	input  wire logic                                 reset_n,
	// Control byte request and answer
	input  wire pdp_pkg::pdp_req_t                    req,
	output logic      [pdp_pkg::BYTE_W-1:0]           rdData,
	output logic                                      rdValid,
	output logic                                      regHit,
	// Divider programming enables held elsewhere
	input  wire logic                                 peripheralDividerProgEnable,
	input  wire logic                                 processorDividerProgEnable,
	// Settings applied to the PLLs
	output pdp_pkg::pdp_pll_t                         peripheralPll,
	output logic      [pdp_pkg::SPREAD_W-1:0]         peripheralSpreadCode,
	output logic                                      processorRefDividerLsb,
	output logic      [pdp_pkg::RATIO_CODE_W-1:0]     processorRatioCode,
	output logic      [pdp_pkg::RATIO_W-1:0]          processorDivideRatio,
	output logic                                      peripheralPllUpdate
);

	// Stored control bytes
	logic [7:0]  mAndNLow_r;         // Byte with M and N bits 2..1
	logic [7:0]  mAndNLow_nxt;
	logic [7:0]  nHigh_r;            // N bits 10..3
	logic [7:0]  nHigh_nxt;
	logic [7:0]  spreadLow_r;        // Spread code low byte
	logic [7:0]  spreadLow_nxt;
	logic [7:0]  spreadHigh_r;       // Spread code high byte
	logic [7:0]  spreadHigh_nxt;
	logic        periphNLsb_r;       // Peripheral N bit 0
	logic        periphNLsb_nxt;
	logic        procNLsb_r;         // Processor N bit 0
	logic        procNLsb_nxt;
	logic [3:0]  ratioCode_r;        // Processor ratio code
	logic [3:0]  ratioCode_nxt;

	// Read answer
	logic [7:0]  rdData_r;
	logic [7:0]  rdData_nxt;
	logic        rdValid_r;
	logic        rdValid_nxt;
	logic        regHit_r;
	logic        regHit_nxt;

	// Applied settings
	pdp_pkg::pdp_pll_t periphPll_r;
	pdp_pkg::pdp_pll_t periphPll_nxt;
	pdp_pkg::pdp_pll_t programmedPll;    // Assembled from the stored bytes
	logic [15:0] spread_r;
	logic [15:0] spread_nxt;
	logic        procLsbOut_r;
	logic        procLsbOut_nxt;
	logic [3:0]  ratioCodeOut_r;
	logic [3:0]  ratioCodeOut_nxt;
	logic [7:0]  ratio_r;
	logic [7:0]  ratio_nxt;
	logic [7:0]  decodedRatio;           // Lookup of the stored code
	logic        update_r;
	logic        update_nxt;

	// True for an index that this block answers
	function automatic logic ownsIndex(input logic [5:0] idx);
		return (idx >= pdp_pkg::IDX_PERIPHERAL_PLL_M_AND_N_LOW) &&
			(idx <= pdp_pkg::IDX_PROCESSOR_OUTPUT_DIVIDER);
	endfunction

	// True for an index in the reserved range
	function automatic logic reservedIndex(input logic [5:0] idx);
		return (idx >= pdp_pkg::IDX_RESERVED_FIRST) &&
			(idx <= pdp_pkg::IDX_RESERVED_LAST);
	endfunction

	// Ratio code lookup
	pdp_ratio_decode #(
		.RATIO_CODE_3  (RATIO_CODE_3),
		.RATIO_CODE_7  (RATIO_CODE_7),
		.RATIO_CODE_11 (RATIO_CODE_11),
		.RATIO_CODE_15 (RATIO_CODE_15)
	) u_ratio (
		.ratioCode   (ratioCode_r),
		.divideRatio (decodedRatio)
	);

	// Write path: each owned byte updates on a write to its index
	always_comb
	begin
		mAndNLow_nxt   = mAndNLow_r;
		nHigh_nxt      = nHigh_r;
		spreadLow_nxt  = spreadLow_r;
		spreadHigh_nxt = spreadHigh_r;
		periphNLsb_nxt = periphNLsb_r;
		procNLsb_nxt   = procNLsb_r;
		ratioCode_nxt  = ratioCode_r;
		// Writes to foreign or reserved bytes are dropped
		if (req.write && ownsIndex(req.index))
		begin
			case (req.index)
				pdp_pkg::IDX_PERIPHERAL_PLL_M_AND_N_LOW:
				begin
					mAndNLow_nxt = req.wdata; // (R1)
				end
				pdp_pkg::IDX_PERIPHERAL_PLL_N_HIGH:
				begin
					nHigh_nxt = req.wdata; // (R2)
				end
				pdp_pkg::IDX_PERIPHERAL_SPREAD_CODE_LOW:
				begin
					spreadLow_nxt = req.wdata; // (R6)
				end
				pdp_pkg::IDX_PERIPHERAL_SPREAD_CODE_HIGH:
				begin
					spreadHigh_nxt = req.wdata; // (R6)
				end
				pdp_pkg::IDX_PERIPHERAL_N_LSB:
				begin
					// Only bit 7 stores, reserved bits are not kept
					periphNLsb_nxt = req.wdata[pdp_pkg::POS_REF_DIVIDER_LSB]; // (R4)
				end
				pdp_pkg::IDX_PROCESSOR_OUTPUT_DIVIDER:
				begin
					procNLsb_nxt  = req.wdata[pdp_pkg::POS_REF_DIVIDER_LSB]; // (R7)
					ratioCode_nxt = req.wdata[pdp_pkg::POS_PROCESSOR_RATIO_CODE_MSB:0]; // (R8)
				end
				default:
				begin
					// Nothing stored
				end
			endcase
		end
	end

	// Control byte storage
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			mAndNLow_r   <= pdp_pkg::RESET_BYTE;
			nHigh_r      <= pdp_pkg::RESET_BYTE;
			spreadLow_r  <= pdp_pkg::RESET_BYTE;
			spreadHigh_r <= pdp_pkg::RESET_BYTE;
			periphNLsb_r <= pdp_pkg::RESET_BIT;
			procNLsb_r   <= pdp_pkg::RESET_BIT;
			ratioCode_r  <= pdp_pkg::RESET_RATIO_CODE;
		end
		else
		begin
			mAndNLow_r   <= mAndNLow_nxt;
			nHigh_r      <= nHigh_nxt;
			spreadLow_r  <= spreadLow_nxt;
			spreadHigh_r <= spreadHigh_nxt;
			periphNLsb_r <= periphNLsb_nxt;
			procNLsb_r   <= procNLsb_nxt;
			ratioCode_r  <= ratioCode_nxt;
		end
	end

	// Read path: answer one cycle after the read strobe
	always_comb
	begin
		rdData_nxt  = pdp_pkg::READ_ZERO;
		rdValid_nxt = req.read;
		regHit_nxt  = 1'b0;
		if (req.read)
		begin
			regHit_nxt = ownsIndex(req.index);
			case (req.index)
				pdp_pkg::IDX_PERIPHERAL_PLL_M_AND_N_LOW:
				begin
					rdData_nxt = mAndNLow_r;
				end
				pdp_pkg::IDX_PERIPHERAL_PLL_N_HIGH:
				begin
					rdData_nxt = nHigh_r;
				end
				pdp_pkg::IDX_PERIPHERAL_SPREAD_CODE_LOW:
				begin
					rdData_nxt = spreadLow_r;
				end
				pdp_pkg::IDX_PERIPHERAL_SPREAD_CODE_HIGH:
				begin
					rdData_nxt = spreadHigh_r;
				end
				pdp_pkg::IDX_PERIPHERAL_N_LSB:
				begin
					// Reserved bits 6..0 read zero
					rdData_nxt = {periphNLsb_r, 7'h00}; // (R11)
				end
				pdp_pkg::IDX_PROCESSOR_OUTPUT_DIVIDER:
				begin
					// Reserved bits 6..4 read zero
					rdData_nxt = {procNLsb_r, 3'h0, ratioCode_r}; // (R11)
				end
				default:
				begin
					// Reserved range and foreign bytes answer zero
					if (reservedIndex(req.index))
					begin
						rdData_nxt = pdp_pkg::READ_ZERO; // (R10)
					end
				end
			endcase
		end
	end

	// Read answer registers
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			rdData_r  <= pdp_pkg::READ_ZERO;
			rdValid_r <= 1'b0;
			regHit_r  <= 1'b0;
		end
		else
		begin
			rdData_r  <= rdData_nxt;
			rdValid_r <= rdValid_nxt;
			regHit_r  <= regHit_nxt;
		end
	end

	// Assemble the programmed dividers from the stored bytes
	always_comb
	begin
		programmedPll.feedbackDiv = mAndNLow_r[pdp_pkg::POS_FEEDBACK_DIVIDER_MSB:0]; // (R1)
		programmedPll.refDiv = {nHigh_r,
			mAndNLow_r[pdp_pkg::POS_REF_DIVIDER_BIT2:pdp_pkg::POS_REF_DIVIDER_BIT1],
			periphNLsb_r}; // (R2) (R4)
	end

	// Applied settings: programmed dividers only while enabled, spread and ratio code always
	always_comb
	begin
		// Disabled programming falls back to the default dividers
		periphPll_nxt.feedbackDiv = pdp_pkg::DEFAULT_FEEDBACK_DIV;
		periphPll_nxt.refDiv      = pdp_pkg::DEFAULT_REF_DIV;
		if (peripheralDividerProgEnable)
		begin
			periphPll_nxt = programmedPll; // (R3) (R5)
		end
		procLsbOut_nxt = processorDividerProgEnable ? procNLsb_r
			: pdp_pkg::DEFAULT_PROC_N_LSB; // (R3)
		spread_nxt       = {spreadHigh_r, spreadLow_r}; // (R6)
		ratioCodeOut_nxt = ratioCode_r;
		ratio_nxt        = decodedRatio; // (R8)
		// Pulse when the applied peripheral dividers change, so the PLL can relock
		update_nxt = (periphPll_nxt != periphPll_r); // (R5)
	end

	// Applied setting registers
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			periphPll_r.feedbackDiv <= pdp_pkg::DEFAULT_FEEDBACK_DIV;
			periphPll_r.refDiv      <= pdp_pkg::DEFAULT_REF_DIV;
			spread_r                <= {pdp_pkg::RESET_BYTE, pdp_pkg::RESET_BYTE};
			procLsbOut_r            <= pdp_pkg::DEFAULT_PROC_N_LSB;
			ratioCodeOut_r          <= pdp_pkg::RESET_RATIO_CODE;
			ratio_r                 <= pdp_pkg::RESET_DIVIDE_RATIO;
			update_r                <= 1'b0;
		end
		else
		begin
			periphPll_r    <= periphPll_nxt;
			spread_r       <= spread_nxt;
			procLsbOut_r   <= procLsbOut_nxt;
			ratioCodeOut_r <= ratioCodeOut_nxt;
			ratio_r        <= ratio_nxt;
			update_r       <= update_nxt;
		end
	end

	// Outputs straight from flip-flops
	assign rdData                 = rdData_r;
	assign rdValid                = rdValid_r;
	assign regHit                 = regHit_r;
	assign peripheralPll          = periphPll_r;
	assign peripheralSpreadCode   = spread_r;
	assign processorRefDividerLsb = procLsbOut_r;
	assign processorRatioCode     = ratioCodeOut_r;
	assign processorDivideRatio   = ratio_r;
	assign peripheralPllUpdate    = update_r;

endmodule

// >>> tb/pdp_regs_monitor.sv
// Checker of the divider register block ports
`timescale 1ns/100ps

module pdp_regs_monitor (
	// Clock and reset
	input wire logic              clk,
	input wire logic              reset_n,
	// Request and read answer
	input wire pdp_pkg::pdp_req_t req,
	input wire logic [7:0]        rdData,
	input wire logic              rdValid,
	input wire logic              regHit,
	// Programming enables
	input wire logic              peripheralDividerProgEnable,
	input wire logic              processorDividerProgEnable,
	// Applied settings
	input wire pdp_pkg::pdp_pll_t peripheralPll,
	input wire logic [15:0]       peripheralSpreadCode,
	input wire logic              processorRefDividerLsb,
	input wire logic [3:0]        processorRatioCode,
	input wire logic [7:0]        processorDivideRatio,
	input wire logic              peripheralPllUpdate
);
	// One clock domain, checks quiet in reset
	default clocking cb @(posedge clk); endclocking
	default disable iff (!reset_n);
	// Short names for the enables and the index
	logic       enP;
	logic       enC;
	logic [5:0] ix;
	logic       wr;
	// Write data two cycles back, for apply checks
	logic [7:0] wdD1;
	logic [7:0] wdD2;
	assign enP = peripheralDividerProgEnable;
	assign enC = processorDividerProgEnable;
	assign ix  = req.index;
	assign wr  = req.write;
	// Delay line of the write byte
	always_ff @(posedge clk)
	begin
		wdD1 <= req.wdata;
		wdD2 <= wdD1;
	end
	a_read_answer: assert property (req.read |=> rdValid
		&& regHit == ($past(ix) >= 6'h0F && $past(ix) <= 6'h14)) else $error("bad read answer");
	a_unowned_zero: assert property (rdValid && !regHit |-> rdData == 8'h00)
		else $error("unowned byte not zero");
	a_resv19_zero: assert property (req.read && ix == 6'h13 |=> rdData[6:0] == 7'h00)
		else $error("byte 19 reserved bits set");
	a_resv20_zero: assert property (req.read && ix == 6'h14 |=> rdData[6:4] == 3'h0)
		else $error("byte 20 reserved bits set");
	a_spread_low: assert property (wr && ix == 6'h11 |=> ##1 peripheralSpreadCode[7:0] == wdD2)
		else $error("spread low byte not applied");
	a_feedback_apply: assert property (wr && ix == 6'h0F && enP ##1 enP |=>
		peripheralPll.feedbackDiv == wdD2[5:0] && peripheralPll.refDiv[2:1] == wdD2[7:6])
		else $error("byte 15 not applied");
	a_ref_high: assert property (wr && ix == 6'h10 && enP ##1 enP |=>
		peripheralPll.refDiv[10:3] == wdD2) else $error("byte 16 not applied");
	a_ref_lsb: assert property (wr && ix == 6'h13 && enP ##1 enP |=>
		peripheralPll.refDiv[0] == wdD2[7]) else $error("byte 19 not applied");
	a_pll_default: assert property (!enP [*2] |=> peripheralPll == 17'h00000)
		else $error("dividers applied while disabled");
	a_proc_lsb: assert property (wr && ix == 6'h14 && enC ##1 enC |=>
		processorRefDividerLsb == wdD2[7]) else $error("processor lsb not applied");
	a_proc_off: assert property (!enC [*2] |=> !processorRefDividerLsb)
		else $error("processor lsb while disabled");
	a_ratio_code: assert property (wr && ix == 6'h14 |=> ##1 processorRatioCode == wdD2[3:0])
		else $error("ratio code not applied");
	a_ratio_40: assert property (processorRatioCode == 4'hE |-> processorDivideRatio == 8'h28)
		else $error("code 1110 not divide by 40");
	// Relock hint stands exactly in the first cycle of a new applied divider pair
	a_update_pulse: assert property (peripheralPllUpdate ==
		(peripheralPll != $past(peripheralPll))) else $error("update pulse wrong");
endmodule

bind pdp_regs pdp_regs_monitor i_mon (
	.clk(clk), .reset_n(reset_n), .req(req), .rdData(rdData), .rdValid(rdValid),
	.regHit(regHit), .peripheralDividerProgEnable(peripheralDividerProgEnable),
	.processorDividerProgEnable(processorDividerProgEnable), .peripheralPll(peripheralPll),
	.peripheralSpreadCode(peripheralSpreadCode), .processorRefDividerLsb(processorRefDividerLsb),
	.processorRatioCode(processorRatioCode), .processorDivideRatio(processorDivideRatio),
	.peripheralPllUpdate(peripheralPllUpdate));

// >>> tb/pdp_host_model.sv
// Bus engine model issuing control byte requests
`timescale 1ns/100ps

module pdp_host_model (
	// Clock
	input wire logic          clk,
	// Request out, read answer in
	output pdp_pkg::pdp_req_t req,
	input wire logic [7:0]    rdData,
	input wire logic          rdValid,
	input wire logic          regHit
);
	// Idle from time zero
	initial req = 16'h0000;
	// One-cycle write strobe; data goes out as given, reserved bits included
	task automatic wr(input logic [5:0] idx, input logic [7:0] dat);
		@(negedge clk);
		req = '{write: 1'h1, read: 1'h0, index: idx, wdata: dat};
		@(negedge clk);
		req = 16'h0000;
	endtask
	// One-cycle read strobe; answer stands the cycle after
	task automatic rd(input logic [5:0] idx, output logic [7:0] dat, output logic v, output logic h);
		@(negedge clk);
		req = '{write: 1'h0, read: 1'h1, index: idx, wdata: 8'h00};
		@(negedge clk);
		req = 16'h0000;
		dat = rdData;
		v = rdValid;
		h = regHit;
	endtask
endmodule

// >>> tb/testbench.sv
// Self-checking bench of the divider register block
`timescale 1ns/100ps

module testbench;
	// Clock, reset and enables
	logic              clk = 1'h0;
	logic              reset_n = 1'h0;
	logic              enP = 1'h0;
	logic              enC = 1'h0;
	// Block connections
	pdp_pkg::pdp_req_t req;
	logic [7:0]        rdData;
	logic              rdValid;
	logic              regHit;
	pdp_pkg::pdp_pll_t pll;
	logic [15:0]       spread;
	logic              lsbC;
	logic [3:0]        code;
	logic [7:0]        ratio;
	logic              upd;
	// Counters, scratch and tables
	int                n_fail = 0;
	int                cmp_count = 0;
	logic [7:0]        d;
	logic              v;
	logic              h;
	logic [7:0]        wv [6] = '{8'hC5, 8'hA3, 8'h5A, 8'h96, 8'hFF, 8'hFB};
	logic [7:0]        rv [6] = '{8'hC5, 8'hA3, 8'h5A, 8'h96, 8'h80, 8'h8B};
	logic [5:0]        resv [4] = '{6'h00, 6'h0E, 6'h15, 6'h3F};
	logic [7:0]        tab [16] = '{8'h02, 8'h03, 8'h05, 8'h0F, 8'h04, 8'h06, 8'h0A, 8'h1E,
		8'h08, 8'h0C, 8'h14, 8'h3C, 8'h10, 8'h18, 8'h28, 8'h78};
	// 125 MHz clock
	always #4 clk = ~clk;
	// Block under test and the bus engine model
	pdp_regs i_dut (.clk(clk), .reset_n(reset_n), .req(req), .rdData(rdData),
		.rdValid(rdValid), .regHit(regHit), .peripheralDividerProgEnable(enP),
		.processorDividerProgEnable(enC), .peripheralPll(pll), .peripheralSpreadCode(spread),
		.processorRefDividerLsb(lsbC), .processorRatioCode(code), .processorDivideRatio(ratio),
		.peripheralPllUpdate(upd));
	pdp_host_model i_host (.clk(clk), .req(req), .rdData(rdData), .rdValid(rdValid),
		.regHit(regHit));
	// Compare and count
	task automatic chk(input logic [63:0] got, input logic [63:0] exp);
		cmp_count++;
		if (got !== exp)
		begin
			n_fail++;
			$display("Error at %0t: got %0h expected %0h", $time, got, exp);
		end
	endtask
	// Read a byte and compare valid, hit and data
	task automatic rdc(input logic [5:0] idx, input logic [7:0] exp, input logic hit);
		i_host.rd(idx, d, v, h);
		chk({v, h, d}, {1'h1, hit, exp});
	endtask
	// Outputs and all bytes at their reset values
	task automatic rst_chk();
		chk({pll, spread, lsbC, code, ratio, upd}, {17'h0, 16'h0, 1'h0, 4'h0, 8'h02, 1'h0});
		for (int i = 0; i < 6; i++)
			rdc(6'(15 + i), 8'h00, 1'h1);
	endtask
	// Counts, verdict, end of run
	task automatic stop_test();
		$display("Compares %0d, mismatches %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	// Watchdog against a hung handshake
	initial
	begin
		#160000;
		n_fail++;
		stop_test();
	end
	// Test sequence
	initial
	begin
		repeat (20) @(negedge clk);
		reset_n = 1'h1;
		rst_chk();
		// Program all bytes with enables low
		for (int i = 0; i < 6; i++)
			i_host.wr(6'(15 + i), wv[i]);
		// Foreign and reserved places take nothing and read zero
		for (int i = 0; i < 4; i++)
		begin
			i_host.wr(resv[i], 8'h3C);
			rdc(resv[i], 8'h00, 1'h0);
		end
		// Read back, reserved bits cleared
		for (int i = 0; i < 6; i++)
			rdc(6'(15 + i), rv[i], 1'h1);
		chk({pll, lsbC}, {17'h0, 1'h0});
		chk({spread, code, ratio}, {16'h965A, 4'hB, 8'h3C});
		// Enables on: assembled dividers applied
		enP = 1'h1;
		enC = 1'h1;
		repeat (3) @(negedge clk);
		chk({pll, lsbC}, {6'h05, 8'hA3, 2'h3, 1'h1, 1'h1});
		// Every ratio code, processor lsb toggling
		for (int c = 0; c < 16; c++)
		begin
			i_host.wr(6'h14, {c[0], 3'h0, 4'(c)});
			repeat (2) @(negedge clk);
			chk({code, ratio, lsbC}, {4'(c), tab[c], c[0]});
		end
		// Divider bytes written while enabled: applied the cycle after the store, one relock pulse
		i_host.wr(6'h0F, 8'h3A);
		chk(upd, 1'h0);
		@(negedge clk);
		chk({pll, upd}, {6'h3A, 8'hA3, 2'h0, 1'h1, 1'h1});
		@(negedge clk);
		chk(upd, 1'h0);
		i_host.wr(6'h10, 8'h5C);
		i_host.wr(6'h13, 8'h00);
		repeat (2) @(negedge clk);
		chk(pll, {6'h3A, 8'h5C, 2'h0, 1'h0});
		// Enables off again: defaults return
		enP = 1'h0;
		enC = 1'h0;
		repeat (3) @(negedge clk);
		chk({pll, lsbC}, {17'h0, 1'h0});
		// Reset in mid-run
		enP = 1'h1;
		reset_n = 1'h0;
		repeat (2) @(negedge clk);
		reset_n = 1'h1;
		rst_chk();
		stop_test();
	end
endmodule
